// ==== hdl/keypad_irq_pkg.sv ====
// package: keypad interrupt unit register map, fields and reset values
package keypad_irq_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PINS   = 8;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 32;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;  // status and control
  localparam logic [ADDR_W-1:0] OFS_PIN_EN = 4'h4;  // per-pin enables
  localparam logic [ADDR_W-1:0] OFS_DIR    = 4'h8;  // port direction
  localparam logic [ADDR_W-1:0] OFS_DATA   = 4'hC;  // port data

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_EDGE_LEVEL = 0;  // edge_level_select
  localparam int unsigned BIT_MASK       = 1;  // interrupt_mask
  localparam int unsigned BIT_ACK        = 2;  // acknowledge_bit, write only
  localparam int unsigned BIT_PENDING    = 3;  // pending_flag, read only

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PIN_EN = 8'h00;
  localparam logic [7:0] RST_DIR    = 8'h00;
  localparam logic [7:0] RST_DATA   = 8'h00;
  localparam logic       RST_MODE   = 1'b0;
  localparam logic       RST_MASK   = 1'b0;
endpackage

// ==== hdl/keypad_edge_detect.sv ====
// per-pin falling edge detector on already synchronous pin levels
`timescale 1ns/1ps
module keypad_edge_detect #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  // pin levels and edges
  input  wire logic [WIDTH-1:0] i_level,
  output logic      [WIDTH-1:0] o_fall
);
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] prev_nxt;

  // previous level; resets high so an idle pin shows no edge
  always_comb begin
    prev_nxt = i_level;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_r <= '1;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // one generate slice per pin
  for (genvar g = 0; g < WIDTH; g++) begin : g_pin
    assign o_fall[g] = prev_r[g] & ~i_level[g];
  end
endmodule

// ==== hdl/keypad_wb_slave.sv ====
// classic wishbone slave front end: decode and one-cycle ack
`timescale 1ns/1ps
module keypad_wb_slave #(
  parameter int unsigned ADDR_W = 4
) (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  // wishbone request
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADDR_W-1:0] i_wb_adr,
  // decoded strobes
  output logic                   o_wr_stb,
  output logic                   o_rd_stb,
  output logic                   o_ack
);
  logic ack_r;
  logic ack_nxt;

  // ack one cycle after request, dropped the cycle after
  always_comb begin
    ack_nxt = i_wb_cyc & i_wb_stb & ~ack_r;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // accesses take effect at the acking edge only
  assign o_ack    = ack_r;
  assign o_wr_stb = ack_nxt & i_wb_we;
  assign o_rd_stb = ack_nxt & ~i_wb_we;
endmodule

// ==== hdl/keypad_irq_unit.sv ====
// keypad interrupt unit: pin enables, edge/level request, wishbone registers
`timescale 1ns/1ps
module keypad_irq_unit
  import keypad_irq_pkg::*;
#(
  parameter int unsigned PINS = NUM_PINS
) (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  // wishbone slave
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADDR_W-1:0] i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [DATA_W-1:0] i_wb_dat,
  output logic      [DATA_W-1:0] o_wb_dat,
  output logic                   o_wb_ack,
  // processor side
  input  wire logic              i_vector_fetch,
  output logic                   o_irq,
  output logic                   o_wake,
  // port pins
  input  wire logic [PINS-1:0]   i_pin,
  output logic      [PINS-1:0]   o_pin,
  output logic      [PINS-1:0]   o_pin_oe_n,
  output logic      [PINS-1:0]   o_pullup_en
);
  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  logic wr_stb;
  logic rd_stb;
  logic ack_w;

  keypad_wb_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_wb_cyc  (i_wb_cyc),
    .i_wb_stb  (i_wb_stb),
    .i_wb_we   (i_wb_we),
    .i_wb_adr  (i_wb_adr),
    .o_wr_stb  (wr_stb),
    .o_rd_stb  (rd_stb),
    .o_ack     (ack_w)
  );

  assign o_wb_ack = ack_w;

  // ----------------------------------------------------------------
  // pin edge detection
  // ----------------------------------------------------------------
  logic [PINS-1:0] fall;

  keypad_edge_detect #(
    .WIDTH (PINS)
  ) u_edge (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_level   (i_pin),
    .o_fall    (fall)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [PINS-1:0]   pin_irq_enable_r;
  logic [PINS-1:0]   pin_irq_enable_nxt;
  logic [PINS-1:0]   port_direction_bits_r;
  logic [PINS-1:0]   port_direction_bits_nxt;
  logic [PINS-1:0]   port_data_r;
  logic [PINS-1:0]   port_data_nxt;
  logic              edge_level_select_r;
  logic              edge_level_select_nxt;
  logic              interrupt_mask_r;
  logic              interrupt_mask_nxt;
  logic              latch_r;
  logic              latch_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic              wake_r;
  logic              wake_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [PINS-1:0]   pin_out_r;
  logic [PINS-1:0]   pin_out_nxt;
  logic [PINS-1:0]   pin_oe_n_r;
  logic [PINS-1:0]   pin_oe_n_nxt;
  logic [PINS-1:0]   pullup_r;
  logic [PINS-1:0]   pullup_nxt;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // true when a write hits the given offset with the low lane selected
  function automatic logic hit(input logic [ADDR_W-1:0] ofs);
    hit = wr_stb && (i_wb_adr == ofs) && i_wb_sel[0];
  endfunction

  logic            wr_ctrl;
  logic            sw_ack;
  logic            clear_evt;
  logic [PINS-1:0] low_enabled;
  logic            any_low;
  logic            any_fall;

  assign wr_ctrl     = hit(OFS_CTRL);
  assign sw_ack      = wr_ctrl & i_wb_dat[BIT_ACK];
  assign clear_evt   = sw_ack | i_vector_fetch;
  assign low_enabled = pin_irq_enable_nxt & ~i_pin;
  assign any_low     = |low_enabled;
  assign any_fall    = |(fall & pin_irq_enable_r);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // plain read/write registers; writes take effect at the acking edge
  always_comb begin
    pin_irq_enable_nxt      = pin_irq_enable_r;
    port_direction_bits_nxt = port_direction_bits_r;
    port_data_nxt           = port_data_r;
    edge_level_select_nxt   = edge_level_select_r;
    interrupt_mask_nxt      = interrupt_mask_r;
    if (wr_ctrl) begin
      edge_level_select_nxt = i_wb_dat[BIT_EDGE_LEVEL];
      interrupt_mask_nxt    = i_wb_dat[BIT_MASK];
    end else if (hit(OFS_PIN_EN)) begin
      pin_irq_enable_nxt = i_wb_dat[PINS-1:0];
    end else if (hit(OFS_DIR)) begin
      port_direction_bits_nxt = i_wb_dat[PINS-1:0];
    end else if (hit(OFS_DATA)) begin
      port_data_nxt = i_wb_dat[PINS-1:0];
    end
  end

  // mode bit returns to edge-only on reset
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_irq_enable_r      <= RST_PIN_EN[PINS-1:0];
      port_direction_bits_r <= RST_DIR[PINS-1:0];
      port_data_r           <= RST_DATA[PINS-1:0];
      edge_level_select_r   <= RST_MODE;
      interrupt_mask_r      <= RST_MASK;
    end else begin
      pin_irq_enable_r      <= pin_irq_enable_nxt;
      port_direction_bits_r <= port_direction_bits_nxt;
      port_data_r           <= port_data_nxt;
      edge_level_select_r   <= edge_level_select_nxt;
      interrupt_mask_r      <= interrupt_mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // latch_r records a falling edge not yet acknowledged; an edge in the
  // same cycle as the clear wins so no key press is lost.
  // the request itself is the latch, or in level mode the latch plus
  // any enabled pin still held low, so the clear and the pin release
  // may happen in either order.
  always_comb begin
    latch_nxt = latch_r;
    if (clear_evt) begin
      latch_nxt = 1'b0;
    end
    if (any_fall) begin
      latch_nxt = 1'b1;
    end
    // the request is the latch or the level hold; either alone keeps it,
    // so the clear and the pin release may come in either order
    // hold_nxt is built in its own process from latch_nxt, so no loop
    // forms here even though both feed the registered request
    irq_nxt = latch_nxt | hold_nxt;
    // the pending flag reads irq_r, the unmasked request
    // only the output side below is gated by the mask
    // no clock gating here: the unit keeps running in wait and stop
    wake_nxt = irq_nxt & ~interrupt_mask_nxt;
  end

  // level-mode hold: request stays while any enabled pin is low
  logic hold_r;
  logic hold_nxt;

  always_comb begin
    hold_nxt = 1'b0;
    if (edge_level_select_nxt) begin
      hold_nxt = (hold_r | latch_nxt) & any_low;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_r <= 1'b0;
      hold_r  <= 1'b0;
      irq_r   <= 1'b0;
      wake_r  <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      hold_r  <= hold_nxt;
      irq_r   <= irq_nxt;
      wake_r  <= wake_nxt;
    end
  end

  // pending flag is the raw request; the mask only gates the output
  assign o_irq  = wake_r;
  assign o_wake = wake_r;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // unmapped offsets read as zero; pin data reads the pad where the direction bit is clear
  always_comb begin
    rdata_nxt = '0;
    if (rd_stb) begin
      if (i_wb_adr == OFS_CTRL) begin
        rdata_nxt[BIT_EDGE_LEVEL] = edge_level_select_r;
        rdata_nxt[BIT_MASK]       = interrupt_mask_r;
        rdata_nxt[BIT_PENDING]    = irq_r;
      end else if (i_wb_adr == OFS_PIN_EN) begin
        rdata_nxt[PINS-1:0] = pin_irq_enable_r;
      end else if (i_wb_adr == OFS_DIR) begin
        rdata_nxt[PINS-1:0] = port_direction_bits_r;
      end else if (i_wb_adr == OFS_DATA) begin
        rdata_nxt[PINS-1:0] = (port_direction_bits_r & port_data_r)
                            | (~port_direction_bits_r & i_pin);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_wb_dat = rdata_r;

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // enable overrides direction; pull-up keeps an idle key high, but a
  // freshly enabled pin may still read low without raising a request, as only a falling edge latches one
  always_comb begin
    pin_out_nxt  = port_data_nxt;
    pin_oe_n_nxt = ~(port_direction_bits_nxt & ~pin_irq_enable_nxt);
    pullup_nxt   = pin_irq_enable_nxt;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_out_r  <= '0;
      pin_oe_n_r <= '1;
      pullup_r   <= '0;
    end else begin
      pin_out_r  <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
      pullup_r   <= pullup_nxt;
    end
  end

  assign o_pin       = pin_out_r;
  assign o_pin_oe_n  = pin_oe_n_r;
  assign o_pullup_en = pullup_r;
endmodule

// ==== verification/keypad_irq_unit_asserts.sv ====
// checker: port assertions for the keypad interrupt unit, bound below
`timescale 1ns/1ps
module keypad_irq_unit_asserts
  import keypad_irq_pkg::*;
#(
  parameter int unsigned PINS = NUM_PINS
) (
  // clock, reset and bus
  input wire logic              i_clk_sys,
  input wire logic              i_rst_n,
  input wire logic              i_wb_cyc,
  input wire logic              i_wb_stb,
  input wire logic              i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0]        i_wb_sel,
  input wire logic [DATA_W-1:0] i_wb_dat,
  input wire logic [DATA_W-1:0] o_wb_dat,
  input wire logic              o_wb_ack,
  // processor side and pins
  input wire logic              i_vector_fetch,
  input wire logic              o_irq,
  input wire logic              o_wake,
  input wire logic [PINS-1:0]   i_pin,
  input wire logic [PINS-1:0]   o_pin,
  input wire logic [PINS-1:0]   o_pin_oe_n,
  input wire logic [PINS-1:0]   o_pullup_en
);
  // ----------------------------------------------------------------
  // shadow state
  // ----------------------------------------------------------------
  logic            mode_r, mode_nxt, wr_ok;
  logic [PINS-1:0] en_r, en_nxt, low_en;
  // mode and enables follow writes on the edge that samples ack
  always_comb begin
    wr_ok    = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0];
    mode_nxt = (wr_ok && i_wb_adr == OFS_CTRL) ? i_wb_dat[BIT_EDGE_LEVEL] : mode_r;
    en_nxt   = (wr_ok && i_wb_adr == OFS_PIN_EN) ? i_wb_dat[PINS-1:0] : en_r;
    low_en   = ~i_pin & o_pullup_en;
  end
  // registers only
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= RST_MODE;
      en_r   <= PINS'(RST_PIN_EN);
    end else begin
      mode_r <= mode_nxt;
      en_r   <= en_nxt;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_reset_quiet: assert property (disable iff (1'b0)
    !i_rst_n |-> !o_irq && &o_pin_oe_n && o_pullup_en == '0) else $error("active in reset");
  a_wake_irq: assert property (o_wake == o_irq) else $error("wake differs");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack");
  a_idle_dat: assert property (!o_wb_ack |-> o_wb_dat == '0) else $error("data outside ack");
  a_input_forced: assert property ((o_pullup_en & ~o_pin_oe_n) == '0)
    else $error("enabled pin driven");
  a_pullup_shadow: assert property (!i_wb_cyc && !$past(i_wb_cyc) |-> o_pullup_en == en_r)
    else $error("pull-up differs");
  a_level_hold: assert property (mode_r && o_irq && |low_en && !i_wb_cyc &&
    !$past(i_wb_cyc) |=> o_irq) else $error("level request dropped");
  a_fetch_clears: assert property (i_vector_fetch && !i_wb_cyc && low_en == '0
    ##1 low_en == '0 |=> !o_irq) else $error("fetch kept request");
  // main scenarios
  c_fetch: cover property (o_irq && i_vector_fetch);
  c_level: cover property (mode_r && o_irq && |low_en);
  c_write: cover property (wr_ok);
endmodule

bind keypad_irq_unit keypad_irq_unit_asserts #(.PINS(PINS)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_vector_fetch(i_vector_fetch),
  .o_irq(o_irq), .o_wake(o_wake), .i_pin(i_pin), .o_pin(o_pin),
  .o_pin_oe_n(o_pin_oe_n), .o_pullup_en(o_pullup_en));

// ==== verification/key_switch_model.sv ====
// key switch model: pads with slow pull-ups, port drive and pressed keys
`timescale 1ns/1ps
module key_switch_model #(
  parameter int unsigned PINS = 8,
  parameter int unsigned RISE = 4
) (
  // clock
  input  wire logic            i_clk_sys,
  // keys and pad controls
  input  wire logic [PINS-1:0] i_press,
  input  wire logic [PINS-1:0] i_drive,
  input  wire logic [PINS-1:0] i_oe_n,
  input  wire logic [PINS-1:0] i_pullup_en,
  output logic      [PINS-1:0] o_pad
);
  logic [PINS-1:0] last_r = '0;
  int unsigned     rise_r [PINS];
  // pull-up charge time: a low pad stays low a while after enabling
  always_ff @(posedge i_clk_sys) begin
    last_r <= o_pad;
    for (int i = 0; i < PINS; i++) begin
      rise_r[i] <= i_pullup_en[i] ? ((rise_r[i] < RISE) ? rise_r[i] + 1 : RISE) : 0;
    end
  end
  // drive wins, then key; a bare pad flips so no stale level survives
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (!i_oe_n[i]) o_pad[i] = i_drive[i];
      else if (i_press[i]) o_pad[i] = 1'b0;
      else if (i_pullup_en[i]) o_pad[i] = (rise_r[i] >= RISE) ? 1'b1 : last_r[i];
      else o_pad[i] = ~last_r[i];
    end
  end
endmodule

// ==== verification/test_keypad_irq_unit.sv ====
// bench: register-level tests of the keypad interrupt unit
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module test_keypad_irq_unit
  import keypad_irq_pkg::*;
;
  logic              clk = 1'b0, rst_n = 1'b1, cyc = 1'b0, we = 1'b0, vf = 1'b0, ack;
  logic [ADDR_W-1:0] adr = '0;
  logic [7:0]        wd = '0, rd, press = '0, pin, opin, oe_n, pu;
  logic [DATA_W-1:0] rdat;
  logic              irq, wake;
  int                n_mismatch = 0, tests_run = 0;
  always #5 clk = ~clk;
  keypad_irq_unit dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(cyc),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat({24'h00_0000, wd}),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_vector_fetch(vf), .o_irq(irq), .o_wake(wake),
    .i_pin(pin), .o_pin(opin), .o_pin_oe_n(oe_n), .o_pullup_en(pu));
  key_switch_model #(.PINS(8)) keys (.i_clk_sys(clk), .i_press(press), .i_drive(opin),
    .i_oe_n(oe_n), .i_pullup_en(pu), .o_pad(pin));
  // ----------------------------------------------------------------
  // bus and pin tasks
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1; we <= w; adr <= a; wd <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin n_mismatch++; $display("ERROR %0t: no ack", $time); end
    rd = rdat[7:0];
    cyc <= 1'b0;
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // keys change after an edge, then four edges let the request settle
  task automatic key(input logic [7:0] p);
    @(posedge clk);
    press <= p;
    tick(4);
  endtask
  task automatic fetch;
    @(posedge clk); vf <= 1'b1;
    @(posedge clk); vf <= 1'b0;
    tick(2);
  endtask
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    tick(5000);
    n_mismatch++;
    finish_test;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n <= 1'b0;
    tick(10);
    rst_n <= 1'b1;
    rchk(OFS_CTRL, 8'h00);
    rchk(OFS_PIN_EN, RST_PIN_EN);
    rchk(OFS_DIR, RST_DIR);
    wb(1'b1, OFS_CTRL, 8'h02);
    wb(1'b1, OFS_PIN_EN, 8'h0F);
    tick(2);
    `CHK({pu, oe_n}, 16'h0FFF)
    wb(1'b1, OFS_CTRL, 8'h06);
    rchk(OFS_CTRL, 8'h02);
    key(8'h02);
    `CHK(irq, 1'b0)
    rchk(OFS_CTRL, 8'h0A);
    wb(1'b1, OFS_CTRL, 8'h06);
    tick(4);
    rchk(OFS_CTRL, 8'h02);
    key(8'h00);
    wb(1'b1, OFS_CTRL, 8'h00);
    key(8'h04);
    `CHK({irq, wake}, 2'b11)
    fetch;
    `CHK(irq, 1'b0)
    key(8'h20);
    `CHK(irq, 1'b0)
    key(8'h00);
    wb(1'b1, OFS_CTRL, 8'h03);
    wb(1'b1, OFS_PIN_EN, 8'h1F);
    tick(8);
    wb(1'b1, OFS_CTRL, 8'h07);
    rchk(OFS_CTRL, 8'h03);
    wb(1'b1, OFS_CTRL, 8'h01);
    key(8'h01);
    wb(1'b1, OFS_CTRL, 8'h05);
    tick(3);
    `CHK(irq, 1'b1)
    key(8'h00);
    `CHK(irq, 1'b0)
    key(8'h01);
    key(8'h00);
    `CHK(irq, 1'b1)
    fetch;
    `CHK(irq, 1'b0)
    wb(1'b1, OFS_DIR, 8'h80);
    wb(1'b1, OFS_DATA, 8'h80);
    tick(2);
    `CHK({opin[7], oe_n[7]}, 2'b10)
    wb(1'b0, OFS_DATA, 8'h00);
    `CHK(rd & 8'h9F, 8'h9F)
    wb(1'b1, OFS_PIN_EN, 8'h9F);
    tick(2);
    `CHK({pu[7], oe_n[7], irq}, 3'b110)
    wb(1'b1, 4'h2, 8'hFF);
    rchk(4'h2, 8'h00);
    key(8'h01);
    `CHK(irq, 1'b1)
    rst_n <= 1'b0;
    tick(2);
    `CHK(irq, 1'b0)
    rst_n <= 1'b1;
    rchk(OFS_CTRL, 8'h00);
    `CHK(irq, 1'b0)
    finish_test;
  end
endmodule
